// ---- logic/mdsr_status_bank.sv ----
/*
 * status register bank, read-only except the interrupt enable and clear registers, of a stepper driver with fault pin and interrupt.
 * assumes synchronous condition inputs from the power stage and protection circuits,
 * a plain register port with read data one cycle after the strobe.
 */
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns
module mdsr_status_bank (
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	// register port
	input wire mdsr_pkg::mdsr_addr_t regAddr,
	input wire mdsr_pkg::mdsr_data_t regWrData,
	input wire logic regWrStrobe,
	input wire logic regRdStrobe,
	output logic [mdsr_pkg::DATA_W-1:0] regRdData,
	// fault conditions
	input wire logic protocolErrorActive,
	input wire logic supplyUndervoltage,
	input wire logic pumpUndervoltage,
	input wire logic [7:0] overcurrentDetailIn,
	input wire logic thermalWarning,
	input wire logic thermalShutdown,
	input wire logic stallDetect,
	input wire logic openLoadA,
	input wire logic openLoadB,
	// further diagnostics
	input wire logic standstillSaving,
	input wire logic stallLearnOk,
	input wire logic torqueLearnDone,
	input wire logic [7:0] indexerPowerIn,
	// fault clear requests
	input wire logic clearFaultsBit,
	input wire logic sleepInputN,
	// open-drain fault pin
	input wire logic faultPinIn,
	output logic faultPinOut,
	output logic faultPinOe,
	// interrupt
	output logic irq
);
	import mdsr_pkg::*;

	typedef struct packed {
		mdsr_data_t fault;
		mdsr_data_t ocDetail;
		mdsr_data_t thermStall;
		mdsr_data_t indexerPower;
		mdsr_data_t rdData;
		logic pinOut;
		logic pinOe;
	} mdsr_bank_state_s;

	mdsr_bank_state_s state_q;
	mdsr_bank_state_s state_d;

	mdsr_irq_if #(.WIDTH(IRQ_W)) irqBus ();

	logic clearRequest;
	logic [IRQ_W-1:0] faultRise;
	logic pinContention;

	// a low sleep input is taken as the reset pulse that clears latched faults
	assign clearRequest = clearFaultsBit | ~sleepInputN;

	always_comb begin
		state_d = state_q;
		state_d.ocDetail = overcurrentDetailIn;
		state_d.fault[FLT_SUPPLY_UV] = supplyUndervoltage;
		state_d.fault[FLT_PUMP_UV] = pumpUndervoltage;
		state_d.fault[FLT_OVERCURRENT] = |overcurrentDetailIn;
		state_d.fault[FLT_STALL] = stallDetect;
		state_d.fault[FLT_THERMAL] = thermalWarning | thermalShutdown;
		state_d.fault[FLT_OPEN_LOAD] = openLoadA | openLoadB;
		// latched: a live error keeps it set even against a clear
		if (protocolErrorActive) begin
			state_d.fault[FLT_PROTOCOL] = 1'b1;
		end else if (clearRequest) begin
			state_d.fault[FLT_PROTOCOL] = 1'b0;
		end
		state_d.fault[FLT_SUMMARY] = |state_d.fault[FLT_PROTOCOL:FLT_OPEN_LOAD];
		state_d.thermStall = REG_RESET;
		state_d.thermStall[THS_STANDSTILL] = standstillSaving;
		state_d.thermStall[THS_WARNING] = thermalWarning;
		state_d.thermStall[THS_SHUTDOWN] = thermalShutdown;
		state_d.thermStall[THS_STALL_LEARN_OK] = stallLearnOk;
		state_d.thermStall[THS_STALL] = stallDetect;
		state_d.thermStall[THS_TORQUE_LEARN] = torqueLearnDone;
		state_d.thermStall[THS_OPEN_LOAD_B] = openLoadB;
		state_d.thermStall[THS_OPEN_LOAD_A] = openLoadA;
		state_d.indexerPower = indexerPowerIn & INDEXER_POWER_MASK;
		// open drain: only ever drive low
		state_d.pinOut = 1'b0;
		state_d.pinOe = state_d.fault[FLT_SUMMARY];
		// read data live for one cycle only; writes reach only the interrupt enable and clear registers
		state_d.rdData = DATA_ZERO;
		if (regRdStrobe) begin
			if (regAddr == ADDR_FAULT) begin
				state_d.rdData = state_q.fault;
			end else if (regAddr == ADDR_OC_DETAIL) begin
				state_d.rdData = state_q.ocDetail;
			end else if (regAddr == ADDR_THERM_STALL) begin
				state_d.rdData = state_q.thermStall;
			end else if (regAddr == ADDR_INDEXER_POWER) begin
				state_d.rdData = state_q.indexerPower;
			end else if (regAddr == ADDR_IRQ_STATUS) begin
				state_d.rdData = irqBus.status;
			end else if (regAddr == ADDR_IRQ_ENABLE) begin
				state_d.rdData = irqBus.enable;
			end else begin
				state_d.rdData = DATA_ZERO;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	// rising edges of fault bits 6 to 0 feed the interrupt, bit 7 is contention; the pin seen low while
	// released means another device on the wired line reports a fault
	assign pinContention = ~faultPinIn & ~state_q.pinOe;
	always_comb begin
		faultRise = state_d.fault & ~state_q.fault;
		faultRise[IRQ_PIN_CONTENTION] = pinContention;
	end

	assign irqBus.evt = faultRise;
	assign irqBus.wrData = regWrData;
	assign irqBus.clrWr = regWrStrobe && (regAddr == ADDR_IRQ_CLEAR);
	assign irqBus.enWr = regWrStrobe && (regAddr == ADDR_IRQ_ENABLE);

	mdsr_irq_keeper #(.WIDTH(IRQ_W)) irqKeeper (
		.clock(clock),
		.srst(srst),
		.irqBus(irqBus.keeper)
	);

	assign regRdData = state_q.rdData;
	assign faultPinOut = state_q.pinOut;
	assign faultPinOe = state_q.pinOe;
	assign irq = irqBus.irq;

	// helper view of the raw conditions, without indexerPowerIn
	// 3 single conditions, 8 detail bits, 9 more single bits: 20 in all
	logic [19:0] rawConditions;
	assign rawConditions = {protocolErrorActive, supplyUndervoltage, pumpUndervoltage,
		overcurrentDetailIn, thermalWarning, thermalShutdown, stallDetect, openLoadA,
		openLoadB, standstillSaving, stallLearnOk, torqueLearnDone, sleepInputN};

	sequence s_fault_read;
		regRdStrobe && (regAddr == ADDR_FAULT);
	endsequence

	sequence s_clear_allowed;
		clearRequest && !protocolErrorActive;
	endsequence

	property p_write_ignored;
		@(posedge clock) disable iff (srst)
		(regWrStrobe && !clearFaultsBit && $stable(rawConditions))
			|=> $stable(state_q.fault) && $stable(state_q.ocDetail);
	endproperty
	a_write_ignored: assert property (p_write_ignored) else $error("write changed status");

	property p_fault_readback;
		@(posedge clock) disable iff (srst)
		s_fault_read |=> regRdData == $past(state_q.fault);
	endproperty
	a_fault_readback: assert property (p_fault_readback) else $error("bad fault readback");

	property p_detail_readback;
		@(posedge clock) disable iff (srst)
		(regRdStrobe && regAddr == ADDR_OC_DETAIL) |=> regRdData == $past(state_q.ocDetail);
	endproperty
	a_detail_readback: assert property (p_detail_readback) else $error("bad detail read");

	property p_summary;
		@(posedge clock) disable iff (srst)
		state_q.fault[FLT_SUMMARY] == |state_q.fault[FLT_PROTOCOL:FLT_OPEN_LOAD];
	endproperty
	a_summary: assert property (p_summary) else $error("summary flag inconsistent");

	property p_pin_follows;
		@(posedge clock) disable iff (srst)
		(faultPinOe == state_q.fault[FLT_SUMMARY]) && !faultPinOut;
	endproperty
	a_pin_follows: assert property (p_pin_follows) else $error("fault pin wrong");

	property p_proto_set;
		@(posedge clock) disable iff (srst)
		protocolErrorActive |=> state_q.fault[FLT_PROTOCOL] && state_q.fault[FLT_SUMMARY];
	endproperty
	a_proto_set: assert property (p_proto_set) else $error("protocol error not flagged");

	property p_proto_hold;
		@(posedge clock) disable iff (srst)
		(state_q.fault[FLT_PROTOCOL] && !clearRequest) |=> state_q.fault[FLT_PROTOCOL];
	endproperty
	a_proto_hold: assert property (p_proto_hold) else $error("protocol error lost");

	property p_proto_clear;
		@(posedge clock) disable iff (srst)
		s_clear_allowed |=> !state_q.fault[FLT_PROTOCOL];
	endproperty
	a_proto_clear: assert property (p_proto_clear) else $error("protocol error stuck");

	property p_conditions;
		@(posedge clock) disable iff (srst)
		##1 state_q.fault[FLT_SUPPLY_UV] == $past(supplyUndervoltage)
			&& state_q.fault[FLT_PUMP_UV] == $past(pumpUndervoltage)
			&& state_q.fault[FLT_STALL] == $past(stallDetect)
			&& state_q.fault[FLT_OPEN_LOAD] == $past(openLoadA || openLoadB);
	endproperty
	a_conditions: assert property (p_conditions) else $error("condition bit wrong");

	property p_thermal;
		@(posedge clock) disable iff (srst)
		##1 state_q.fault[FLT_THERMAL]
			== (state_q.thermStall[THS_WARNING] || state_q.thermStall[THS_SHUTDOWN]);
	endproperty
	a_thermal: assert property (p_thermal) else $error("thermal summary wrong");

	property p_detail;
		@(posedge clock) disable iff (srst)
		##1 state_q.ocDetail == $past(overcurrentDetailIn);
	endproperty
	a_detail: assert property (p_detail) else $error("detail register wrong");

	property p_reset_zero;
		@(posedge clock)
		srst |=> (state_q.fault == REG_RESET) && (state_q.ocDetail == REG_RESET) && !faultPinOe;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("reset value wrong");

	property p_oc_summary;
		@(posedge clock) disable iff (srst)
		state_q.fault[FLT_OVERCURRENT] == |state_q.ocDetail;
	endproperty
	a_oc_summary: assert property (p_oc_summary) else $error("overcurrent summary wrong");

endmodule

// ---- logic/mdsr_pkg.sv ----
/*
 * constants for the motor driver status register group: offsets, field positions,
 * reset values and the layout of the interrupt registers.
 * assumes an 8-bit register port with byte offsets as printed.
 */
package mdsr_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int IRQ_W = 8;

	typedef logic [ADDR_W-1:0] mdsr_addr_t;
	typedef logic [DATA_W-1:0] mdsr_data_t;

	// status register offsets
	localparam mdsr_addr_t ADDR_FAULT = 8'h00;
	localparam mdsr_addr_t ADDR_OC_DETAIL = 8'h01;
	localparam mdsr_addr_t ADDR_THERM_STALL = 8'h02;
	localparam mdsr_addr_t ADDR_INDEXER_POWER = 8'h03;

	// interrupt registers
	localparam mdsr_addr_t ADDR_IRQ_STATUS = 8'h10;
	localparam mdsr_addr_t ADDR_IRQ_ENABLE = 8'h11;
	localparam mdsr_addr_t ADDR_IRQ_CLEAR = 8'h12;

	// fault register fields
	localparam int FLT_SUMMARY = 7;
	localparam int FLT_PROTOCOL = 6;
	localparam int FLT_SUPPLY_UV = 5;
	localparam int FLT_PUMP_UV = 4;
	localparam int FLT_OVERCURRENT = 3;
	localparam int FLT_STALL = 2;
	localparam int FLT_THERMAL = 1;
	localparam int FLT_OPEN_LOAD = 0;

	// thermal and stall register fields
	localparam int THS_STANDSTILL = 7;
	localparam int THS_WARNING = 6;
	localparam int THS_SHUTDOWN = 5;
	localparam int THS_STALL_LEARN_OK = 4;
	localparam int THS_STALL = 3;
	localparam int THS_TORQUE_LEARN = 2;
	localparam int THS_OPEN_LOAD_B = 1;
	localparam int THS_OPEN_LOAD_A = 0;

	// reserved bits of the indexer and power register read as zero
	localparam mdsr_data_t INDEXER_POWER_MASK = 8'h74;

	// interrupt bit raised when the fault pin is held low by someone else
	localparam int IRQ_PIN_CONTENTION = 7;

	localparam mdsr_data_t REG_RESET = 8'h00;
	localparam mdsr_data_t DATA_ZERO = 8'h00;

endpackage

// ---- logic/mdsr_irq_if.sv ----
/*
 * carrier between the status register bank and its interrupt keeper.
 * assumes one clock domain; the bank owns events and register writes.
 */
`timescale 1ns/1ns
interface mdsr_irq_if #(
	parameter int WIDTH = 8
);
	logic [WIDTH-1:0] evt;
	logic [WIDTH-1:0] wrData;
	logic clrWr;
	logic enWr;
	logic [WIDTH-1:0] status;
	logic [WIDTH-1:0] enable;
	logic irq;

	modport owner (
		output evt,
		output wrData,
		output clrWr,
		output enWr,
		input status,
		input enable,
		input irq
	);

	modport keeper (
		input evt,
		input wrData,
		input clrWr,
		input enWr,
		output status,
		output enable,
		output irq
	);
endinterface

// ---- logic/mdsr_irq_keeper.sv ----
/*
 * sticky interrupt status, enable register and one level interrupt output.
 * assumes events are one-cycle pulses and the clear register is write-one-to-clear.
 */
`timescale 1ns/1ns
module mdsr_irq_keeper #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	// register side
	mdsr_irq_if.keeper irqBus
);
	import mdsr_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] status;
		logic [WIDTH-1:0] enable;
		logic irq;
	} mdsr_irq_state_s;

	mdsr_irq_state_s state_q;
	mdsr_irq_state_s state_d;

	always_comb begin
		state_d = state_q;
		// set wins over a clear in the same cycle
		if (irqBus.clrWr) begin
			state_d.status = state_q.status & ~irqBus.wrData;
		end
		state_d.status = state_d.status | irqBus.evt;
		if (irqBus.enWr) begin
			state_d.enable = irqBus.wrData;
		end
		state_d.irq = |(state_d.status & state_d.enable);
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign irqBus.status = state_q.status;
	assign irqBus.enable = state_q.enable;
	assign irqBus.irq = state_q.irq;

	property p_irq_level;
		@(posedge clock) disable iff (srst)
		state_q.irq == |(state_q.status & state_q.enable);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq level disagrees with status");

	property p_event_sticks;
		@(posedge clock) disable iff (srst)
		(|irqBus.evt) |=> ((state_q.status & $past(irqBus.evt)) == $past(irqBus.evt));
	endproperty
	a_event_sticks: assert property (p_event_sticks) else $error("event not latched");

endmodule

// ---- sim/mdsr_host_model.sv ----
/*
 * host side of the status bank: register port master and the fault wire.
 * assumes the bench calls wr and rd by hierarchical name; pull-up on the wire.
 */
`timescale 1ns/1ns
module mdsr_host_model
	import mdsr_pkg::*;
(
	// clock
	input wire logic clock,
	// register port
	output mdsr_pkg::mdsr_addr_t regAddr,
	output mdsr_pkg::mdsr_data_t regWrData,
	output logic regWrStrobe,
	output logic regRdStrobe,
	input wire mdsr_pkg::mdsr_data_t regRdData,
	// fault wire
	input wire logic pinOe,
	input wire logic pinOut,
	input wire logic otherPullLow,
	output logic faultLine
);
	initial begin
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWrStrobe = 1'b0;
		regRdStrobe = 1'b0;
	end

	// released wire floats up through the pull-up
	assign faultLine = ((pinOe && !pinOut) || otherPullLow) ? 1'b0 : 1'b1;

	// one-cycle strobe, address and data held for that cycle
	task automatic wr(input mdsr_addr_t a, input mdsr_data_t d);
		@(posedge clock);
		regWrStrobe <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clock);
		regWrStrobe <= 1'b0;
	endtask

	// data only valid in the cycle after the strobe edge
	task automatic rd(input mdsr_addr_t a, output mdsr_data_t d);
		@(posedge clock);
		regRdStrobe <= 1'b1;
		regAddr <= a;
		@(posedge clock);
		regRdStrobe <= 1'b0;
		#1;
		d = regRdData;
	endtask
endmodule

// ---- sim/mdsr_status_bank_bench.sv ----
/*
 * self-checking bench for the status bank: register reads, faults, pin, interrupt.
 * assumes the host model drives the register port and resolves the fault wire.
 */
`timescale 1ns/1ns
module mdsr_status_bank_bench;
	import mdsr_pkg::*;

	logic clock = 1'b0;
	logic srst = 1'b1;
	mdsr_addr_t regAddr;
	mdsr_data_t regWrData;
	logic regWrStrobe, regRdStrobe;
	mdsr_data_t regRdData;
	logic protErr = 0, supUv = 0, pumpUv = 0, thWarn = 0, thShut = 0, stall = 0;
	logic olA = 0, olB = 0, stSave = 0, stLrn = 0, tqLrn = 0, clrBit = 0, sleepN = 1;
	logic otherPull = 0;
	logic [7:0] ocDetail = 8'h00;
	logic [7:0] idxPow = 8'h00;
	logic faultLine, pinOut, pinOe, irq;
	int n_errors = 0;
	int n_compared = 0;
	mdsr_data_t rdv;
	mdsr_data_t expTab [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h01, 8'h02};

	always #10 clock = ~clock;

	mdsr_status_bank dut (.clock(clock), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
		.regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
		.protocolErrorActive(protErr), .supplyUndervoltage(supUv), .pumpUndervoltage(pumpUv),
		.overcurrentDetailIn(ocDetail), .thermalWarning(thWarn), .thermalShutdown(thShut),
		.stallDetect(stall), .openLoadA(olA), .openLoadB(olB), .standstillSaving(stSave),
		.stallLearnOk(stLrn), .torqueLearnDone(tqLrn), .indexerPowerIn(idxPow),
		.clearFaultsBit(clrBit), .sleepInputN(sleepN), .faultPinIn(faultLine),
		.faultPinOut(pinOut), .faultPinOe(pinOe), .irq(irq));

	mdsr_host_model host (.clock(clock), .regAddr(regAddr), .regWrData(regWrData),
		.regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
		.pinOe(pinOe), .pinOut(pinOut), .otherPullLow(otherPull), .faultLine(faultLine));

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic rdchk(input mdsr_addr_t a, input mdsr_data_t exp, input string what);
		host.rd(a, rdv);
		chk(what, exp, rdv);
	endtask

	// input sampled at one edge, registered at the next
	task automatic settle();
		repeat (2) @(posedge clock);
	endtask

	task automatic drive(input int k, input logic v);
		case (k)
			0: olA <= v;
			1: thWarn <= v;
			2: stall <= v;
			3: ocDetail <= v ? 8'h10 : 8'h00;
			4: pumpUv <= v;
			5: supUv <= v;
			6: olB <= v;
			default: thShut <= v;
		endcase
	endtask

	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		#200000;
		n_errors++;
		give_verdict();
	end

	initial begin
		repeat (10) @(posedge clock);
		srst <= 1'b0;
		rdchk(ADDR_FAULT, 8'h00, "fault reset");
		rdchk(ADDR_OC_DETAIL, 8'h00, "detail reset");
		rdchk(ADDR_THERM_STALL, 8'h00, "thermal reset");
		host.wr(ADDR_FAULT, 8'hff);
		host.wr(ADDR_OC_DETAIL, 8'hff);
		rdchk(ADDR_FAULT, 8'h00, "fault after write");
		rdchk(8'h20, 8'h00, "unmapped read");
		rdchk(ADDR_IRQ_CLEAR, 8'h00, "clear reg reads zero");
		$display("test reset and read-only done");

		for (int k = 0; k < 8; k++) begin
			drive(k, 1'b1);
			settle();
			rdchk(ADDR_FAULT, expTab[k] | 8'h80, "fault source");
			chk("pin enable", 8'h01, {7'h00, pinOe});
			chk("pin level", 8'h00, {7'h00, faultLine});
			drive(k, 1'b0);
			settle();
			rdchk(ADDR_FAULT, 8'h00, "fault gone");
			chk("pin released", 8'h01, {7'h00, faultLine});
		end
		$display("test fault sources done");

		// one detail bit at a time, both bridges
		for (int b = 0; b < 8; b++) begin
			ocDetail <= 8'h01 << b;
			settle();
			rdchk(ADDR_OC_DETAIL, 8'h01 << b, "detail bit");
			rdchk(ADDR_FAULT, 8'h88, "overcurrent summary");
		end
		ocDetail <= 8'h00;
		thWarn <= 1'b1;
		thShut <= 1'b1;
		stSave <= 1'b1;
		stLrn <= 1'b1;
		tqLrn <= 1'b1;
		idxPow <= 8'hff;
		settle();
		rdchk(ADDR_THERM_STALL, 8'hf4, "thermal stall reg");
		@(posedge clock);
		#1;
		chk("read data after its cycle", 8'h00, regRdData);
		rdchk(ADDR_INDEXER_POWER, INDEXER_POWER_MASK, "indexer reg");
		{thWarn, thShut, stSave, stLrn, tqLrn} <= 5'h00;
		idxPow <= 8'h00;
		$display("test detail and diagnostics done");

		// clear by control bit, then by sleep pulse
		for (int m = 0; m < 2; m++) begin
			protErr <= 1'b1;
			settle();
			rdchk(ADDR_FAULT, 8'hc0, "protocol error");
			if (m == 0) clrBit <= 1'b1; else sleepN <= 1'b0;
			@(posedge clock);
			{clrBit, sleepN} <= 2'b01;
			settle();
			rdchk(ADDR_FAULT, 8'hc0, "clear while active");
			protErr <= 1'b0;
			settle();
			rdchk(ADDR_FAULT, 8'hc0, "sticky after gone");
			if (m == 0) clrBit <= 1'b1; else sleepN <= 1'b0;
			@(posedge clock);
			{clrBit, sleepN} <= 2'b01;
			settle();
			rdchk(ADDR_FAULT, 8'h00, "after clear");
			chk("pin after clear", 8'h00, {7'h00, pinOe});
		end
		$display("test protocol error done");

		host.wr(ADDR_IRQ_CLEAR, 8'hff);
		rdchk(ADDR_IRQ_STATUS, 8'h00, "irq status cleared");
		host.wr(ADDR_IRQ_ENABLE, 8'h20);
		rdchk(ADDR_IRQ_ENABLE, 8'h20, "irq enable");
		supUv <= 1'b1;
		settle();
		supUv <= 1'b0;
		settle();
		rdchk(ADDR_IRQ_STATUS, 8'h20, "irq sticky");
		chk("irq raised", 8'h01, {7'h00, irq});
		host.wr(ADDR_IRQ_ENABLE, 8'h00);
		@(posedge clock);
		chk("irq masked", 8'h00, {7'h00, irq});
		host.wr(ADDR_IRQ_ENABLE, 8'h20);
		host.wr(ADDR_IRQ_CLEAR, 8'h20);
		@(posedge clock);
		chk("irq cleared", 8'h00, {7'h00, irq});
		// someone else holds the released pin low
		host.wr(ADDR_IRQ_ENABLE, 8'h80);
		otherPull <= 1'b1;
		settle();
		otherPull <= 1'b0;
		settle();
		chk("irq contention", 8'h01, {7'h00, irq});
		rdchk(ADDR_IRQ_STATUS, 8'h80, "contention status");
		$display("test interrupt done");
		give_verdict();
	end
endmodule
